/* File: design/rgc_pkg.sv */
// package for the receive level and gain control register bank
// holds register offsets, reset values, field positions and timing counts
// assumes a 20 MHz system clock and an 8-bit register port
`default_nettype none

package rgc_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADC_CLK_CFG_OFS        = 8'h08;
	localparam logic [7:0] MID_TO_LOW_THR_OFS     = 8'h0C;
	localparam logic [7:0] LOW_TO_MID_THR_OFS     = 8'h0D;
	localparam logic [7:0] HIGH_TO_MID_THR_OFS    = 8'h0E;
	localparam logic [7:0] MID_TO_HIGH_THR_OFS    = 8'h0F;
	localparam logic [7:0] MID_GAIN_OFS_OFS       = 8'h10;
	localparam logic [7:0] LOW_GAIN_OFS_OFS       = 8'h11;
	localparam logic [7:0] SETTLE_WAIT_OFS        = 8'h12;
	localparam logic [7:0] ENERGY_SCALE_OFS       = 8'h13;
	localparam logic [7:0] LEVEL_READING_OFS      = 8'h14;
	localparam logic [7:0] FREQ_GAIN_CTRL_OFS     = 8'h15;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] ADC_CLK_CFG_RST        = 8'h10;
	localparam logic [7:0] MID_TO_LOW_THR_RST     = 8'h1E;
	localparam logic [7:0] LOW_TO_MID_THR_RST     = 8'h02;
	localparam logic [7:0] HIGH_TO_MID_THR_RST    = 8'h1E;
	localparam logic [7:0] MID_TO_HIGH_THR_RST    = 8'h02;
	localparam logic [7:0] MID_GAIN_OFS_RST       = 8'h15;
	localparam logic [7:0] LOW_GAIN_OFS_RST       = 8'h2B;
	localparam logic [7:0] SETTLE_WAIT_RST        = 8'h01;
	localparam logic [7:0] ENERGY_SCALE_RST       = 8'hD4;
	localparam logic [7:0] LEVEL_READING_RST      = 8'h00;
	localparam logic [7:0] FREQ_GAIN_CTRL_RST     = 8'h82;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int ADC_CLK_SEL_BIT      = 4;
	localparam int LEVEL_MSB            = 5;
	localparam int CONV_SET_MSB         = 5;
	localparam int CONV_SET_LSB         = 4;
	localparam int SETTLE_SET_MSB       = 3;
	localparam int MULT_MSB             = 7;
	localparam int MULT_LSB             = 4;
	localparam int DIV8_BIT             = 3;
	localparam int DIV4_BIT             = 2;
	localparam int DIV2_BIT             = 1;
	localparam int DIV1_BIT             = 0;
	localparam int FREQ_CORR_EN_BIT     = 7;
	localparam int MODE_MSB             = 1;

	// interval offsets added to the programmed settings
	localparam logic [2:0] CONV_EXTRA   = 3'h2;
	localparam logic [4:0] SETTLE_EXTRA = 5'h01;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS        = 50;
	localparam int ADC_FAST_PERIOD_NS   = 16000;
	localparam int ADC_SLOW_PERIOD_NS   = 18500;
	localparam logic [8:0] ADC_FAST_CYC = 9'(ADC_FAST_PERIOD_NS / CLK_PERIOD_NS);
	localparam logic [8:0] ADC_SLOW_CYC = 9'(ADC_SLOW_PERIOD_NS / CLK_PERIOD_NS);

	// ------------------------------------------------------------
	// enumerations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		RGC_GAIN_HIGH = 2'b00,
		RGC_GAIN_MID  = 2'b01,
		RGC_GAIN_LOW  = 2'b10
	} rgc_gain_t;

	localparam logic [1:0] MODE_HIGH_FIX  = 2'b00;
	localparam logic [1:0] MODE_HIGH_MID  = 2'b01;
	localparam logic [1:0] MODE_ALL_GAINS = 2'b10;

endpackage

`default_nettype wire

/* File: design/rgc_level_gain_regs.sv */
// register bank and gain switching logic for the receive level measurement
// assumes: register port on clk_sys, level and temperature-busy pins from the
// shared level/temperature converter, which are asynchronous to clk_sys
//
// Functional notes
// - middle-gain level offset, six bits, resets to 01_0101
// - low-gain level offset, six bits, resets to 10_1011
// - convergence wait of setting plus two samples blocks further switching
// - no level-driven gain change before convergence wait ends, whatever the level; a mode write still pulls gain back at once
// - after each switch, settle wait of setting plus one samples
// - samples within the settle wait do not update the energy value
// - sample period 16 us at fast clock, 18.5 us at slow clock
// - scale multiplier in top nibble, range 1 to 15, resets to 1101
// - divisor bits 1/8,1/4,1/2,1/1; highest set bit wins
// - scale is multiplier times divisor; empty divisor field means 1/1
// - scale register all zero gives a scale of one
// - six-bit level reading, read only, refreshed every sample period
// - reading holds its value during temperature conversion
// - frequency correction enable in bit 7, resets enabled
// - gain mode: high fixed, high-mid, high-mid-low, reserved
// - converter clock select: 0 slow, 1 fast, fast at reset
//
// Implementation choice: the strobed register port.
`default_nettype none

module rgc_level_gain_regs
	import rgc_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              clk_en,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	input  wire logic [5:0]        adc_level_pin,
	input  wire logic              temp_busy_pin,
	output logic      [1:0]        gain_sel,
	output logic                   freq_correction_enable,
	output logic                   adc_clk_fast,
	output logic                   sample_tick,
	output logic      [10:0]       energy_value,
	output logic                   energy_valid
);
	import rgc_pkg::*;

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	// the decode reads all eight low address bits, so narrower ports cannot be served
	if (ADDR_W < 8 || ADDR_W > 16) begin : g_bad_addr
		$error("address width must be 8 to 16 bits");
	end

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [7:0]  adc_clk_cfg_reg;
	logic [7:0]  mid_to_low_threshold_reg;
	logic [7:0]  low_to_mid_threshold_reg;
	logic [7:0]  high_to_mid_threshold_reg;
	logic [7:0]  mid_to_high_threshold_reg;
	logic [7:0]  mid_gain_level_offset_reg;
	logic [7:0]  low_gain_level_offset_reg;
	logic [7:0]  level_settle_wait_reg;
	logic [7:0]  energy_scale_factor_reg;
	logic [1:0]  reading_spare_reg;
	logic [5:0]  level_reading_reg;
	logic [7:0]  freq_corr_gain_control_reg;
	logic [7:0]  rdata_reg;

	logic [5:0]  level_meta_reg;
	logic [5:0]  level_sync_reg;
	logic        busy_meta_reg;
	logic        busy_sync_reg;

	logic [8:0]  period_cnt_reg;
	logic        tick_reg;
	logic [2:0]  conv_cnt_reg;
	logic [4:0]  settle_cnt_reg;
	rgc_gain_t   gain_reg;
	rgc_gain_t   gain_next;
	logic [10:0] energy_reg;
	logic        energy_valid_reg;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	wire logic [7:0] addr8     = reg_addr[7:0];
	wire logic       hi_clear  = (ADDR_W > 8) ? (reg_addr >> 8) == '0 : 1'b1;
	wire logic       wr_go     = clk_en & reg_wr & hi_clear;
	wire logic       wr_clk    = wr_go & (addr8 == ADC_CLK_CFG_OFS);
	wire logic       wr_ml     = wr_go & (addr8 == MID_TO_LOW_THR_OFS);
	wire logic       wr_lm     = wr_go & (addr8 == LOW_TO_MID_THR_OFS);
	wire logic       wr_hm     = wr_go & (addr8 == HIGH_TO_MID_THR_OFS);
	wire logic       wr_mh     = wr_go & (addr8 == MID_TO_HIGH_THR_OFS);
	wire logic       wr_mofs   = wr_go & (addr8 == MID_GAIN_OFS_OFS);
	wire logic       wr_lofs   = wr_go & (addr8 == LOW_GAIN_OFS_OFS);
	wire logic       wr_settle = wr_go & (addr8 == SETTLE_WAIT_OFS);
	wire logic       wr_scale  = wr_go & (addr8 == ENERGY_SCALE_OFS);
	wire logic       wr_read   = wr_go & (addr8 == LEVEL_READING_OFS);
	wire logic       wr_ctrl   = wr_go & (addr8 == FREQ_GAIN_CTRL_OFS);

	// read mux; unmapped offsets answer zero
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		if (hi_clear) begin
			case (addr8)
				ADC_CLK_CFG_OFS:     rd_mux = adc_clk_cfg_reg;
				MID_TO_LOW_THR_OFS:  rd_mux = mid_to_low_threshold_reg;
				LOW_TO_MID_THR_OFS:  rd_mux = low_to_mid_threshold_reg;
				HIGH_TO_MID_THR_OFS: rd_mux = high_to_mid_threshold_reg;
				MID_TO_HIGH_THR_OFS: rd_mux = mid_to_high_threshold_reg;
				MID_GAIN_OFS_OFS:    rd_mux = mid_gain_level_offset_reg;
				LOW_GAIN_OFS_OFS:    rd_mux = low_gain_level_offset_reg;
				SETTLE_WAIT_OFS:     rd_mux = level_settle_wait_reg;
				ENERGY_SCALE_OFS:    rd_mux = energy_scale_factor_reg;
				LEVEL_READING_OFS:   rd_mux = {reading_spare_reg, level_reading_reg};
				FREQ_GAIN_CTRL_OFS:  rd_mux = freq_corr_gain_control_reg;
				default:             rd_mux = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	// plain read/write storage; reserved bits are kept as written
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			adc_clk_cfg_reg            <= ADC_CLK_CFG_RST;
			mid_to_low_threshold_reg   <= MID_TO_LOW_THR_RST;
			low_to_mid_threshold_reg   <= LOW_TO_MID_THR_RST;
			high_to_mid_threshold_reg  <= HIGH_TO_MID_THR_RST;
			mid_to_high_threshold_reg  <= MID_TO_HIGH_THR_RST;
			mid_gain_level_offset_reg  <= MID_GAIN_OFS_RST;
			low_gain_level_offset_reg  <= LOW_GAIN_OFS_RST;
			level_settle_wait_reg      <= SETTLE_WAIT_RST;
			energy_scale_factor_reg    <= ENERGY_SCALE_RST;
			reading_spare_reg          <= LEVEL_READING_RST[7:6];
			freq_corr_gain_control_reg <= FREQ_GAIN_CTRL_RST;
		end else begin
			if (wr_clk)    adc_clk_cfg_reg            <= reg_wdata;
			if (wr_ml)     mid_to_low_threshold_reg   <= reg_wdata;
			if (wr_lm)     low_to_mid_threshold_reg   <= reg_wdata;
			if (wr_hm)     high_to_mid_threshold_reg  <= reg_wdata;
			if (wr_mh)     mid_to_high_threshold_reg  <= reg_wdata;
			if (wr_mofs)   mid_gain_level_offset_reg  <= reg_wdata;
			if (wr_lofs)   low_gain_level_offset_reg  <= reg_wdata;
			if (wr_settle) level_settle_wait_reg      <= reg_wdata;
			if (wr_scale)  energy_scale_factor_reg    <= reg_wdata;
			if (wr_read)   reading_spare_reg          <= reg_wdata[7:6];
			if (wr_ctrl)   freq_corr_gain_control_reg <= reg_wdata;
		end
	end

	// read data stands from the cycle after the strobe until the next cycle with clk_en high
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_reg <= 8'h00;
		end else if (clk_en) begin
			rdata_reg <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// the level bus is only sampled on a tick, long after it settled,
	// so a per-bit synchroniser cannot tear a value in practice
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			level_meta_reg <= 6'h00;
			level_sync_reg <= 6'h00;
			busy_meta_reg  <= 1'b0;
			busy_sync_reg  <= 1'b0;
		end else if (clk_en) begin
			level_meta_reg <= adc_level_pin;
			level_sync_reg <= level_meta_reg;
			busy_meta_reg  <= temp_busy_pin;
			busy_sync_reg  <= busy_meta_reg;
		end
	end

	// ------------------------------------------------------------
	// sample period timer
	// ------------------------------------------------------------
	wire logic       fast_sel   = adc_clk_cfg_reg[ADC_CLK_SEL_BIT];
	wire logic [8:0] period_cyc = fast_sel ? ADC_FAST_CYC : ADC_SLOW_CYC;
	// >= rather than == so a switch to the faster clock mid-period cannot overrun
	wire logic       period_end = (period_cnt_reg >= period_cyc - 9'h001);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			period_cnt_reg <= 9'h000;
			tick_reg       <= 1'b0;
		end else if (clk_en) begin
			period_cnt_reg <= period_end ? 9'h000 : period_cnt_reg + 9'h001;
			tick_reg       <= period_end;
		end
	end

	// a sample is taken on each tick unless a temperature conversion owns the converter
	wire logic take_sample = tick_reg & ~busy_sync_reg;

	// level reading refresh
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			level_reading_reg <= LEVEL_READING_RST[LEVEL_MSB:0];
		end else if (clk_en && take_sample) begin
			level_reading_reg <= level_sync_reg;
		end
	end

	// ------------------------------------------------------------
	// gain switching
	// ------------------------------------------------------------
	wire logic [1:0] mode      = freq_corr_gain_control_reg[MODE_MSB:0];
	wire logic [5:0] lvl       = level_sync_reg;
	wire logic [5:0] thr_hm    = high_to_mid_threshold_reg[LEVEL_MSB:0];
	wire logic [5:0] thr_mh    = mid_to_high_threshold_reg[LEVEL_MSB:0];
	wire logic [5:0] thr_ml    = mid_to_low_threshold_reg[LEVEL_MSB:0];
	wire logic [5:0] thr_lm    = low_to_mid_threshold_reg[LEVEL_MSB:0];
	wire logic       mid_ok    = (mode == MODE_HIGH_MID) | (mode == MODE_ALL_GAINS);
	wire logic       low_ok    = (mode == MODE_ALL_GAINS);
	wire logic       can_move  = take_sample & (conv_cnt_reg == 3'h0);

	// next gain; a mode that no longer allows the active gain pulls back at once
	always_comb begin
		gain_next = gain_reg;
		case (gain_reg)
			RGC_GAIN_HIGH: begin
				if (can_move && mid_ok && lvl > thr_hm) gain_next = RGC_GAIN_MID;
			end
			RGC_GAIN_MID: begin
				if (!mid_ok) gain_next = RGC_GAIN_HIGH;
				else if (can_move && low_ok && lvl > thr_ml) gain_next = RGC_GAIN_LOW;
				else if (can_move && lvl < thr_mh) gain_next = RGC_GAIN_HIGH;
			end
			RGC_GAIN_LOW: begin
				if (!mid_ok) gain_next = RGC_GAIN_HIGH;
				else if (!low_ok) gain_next = RGC_GAIN_MID;
				else if (can_move && lvl < thr_lm) gain_next = RGC_GAIN_MID;
			end
			default: gain_next = RGC_GAIN_HIGH;
		endcase
	end

	wire logic       switching  = (gain_next != gain_reg);
	wire logic [2:0] conv_load  = {1'b0, level_settle_wait_reg[CONV_SET_MSB:CONV_SET_LSB]}
	                              + CONV_EXTRA;
	wire logic [4:0] settle_load = {1'b0, level_settle_wait_reg[SETTLE_SET_MSB:0]}
	                               + SETTLE_EXTRA;

	// gain state and the two wait counters, counted in sample periods
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			gain_reg       <= RGC_GAIN_HIGH;
			conv_cnt_reg   <= 3'h0;
			settle_cnt_reg <= 5'h00;
		end else if (clk_en) begin
			gain_reg <= gain_next;
			if (switching) begin
				conv_cnt_reg   <= conv_load;
				settle_cnt_reg <= settle_load;
			end else if (tick_reg) begin
				if (conv_cnt_reg != 3'h0)   conv_cnt_reg   <= conv_cnt_reg - 3'h1;
				if (settle_cnt_reg != 5'h00) settle_cnt_reg <= settle_cnt_reg - 5'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// energy value
	// ------------------------------------------------------------
	wire logic [3:0] mult_raw = energy_scale_factor_reg[MULT_MSB:MULT_LSB];
	// a zero multiplier is outside the legal range; treating it as one keeps
	// an all-zero register at unity scale
	wire logic [3:0] mult_eff = (mult_raw == 4'h0) ? 4'h1 : mult_raw;
	logic [1:0] div_shift;
	always_comb begin
		div_shift = 2'd0;
		if (energy_scale_factor_reg[DIV8_BIT])      div_shift = 2'd3;
		else if (energy_scale_factor_reg[DIV4_BIT]) div_shift = 2'd2;
		else if (energy_scale_factor_reg[DIV2_BIT]) div_shift = 2'd1;
		else if (energy_scale_factor_reg[DIV1_BIT]) div_shift = 2'd0;
	end

	logic [5:0] active_ofs;
	always_comb begin
		case (gain_reg)
			RGC_GAIN_MID: active_ofs = mid_gain_level_offset_reg[LEVEL_MSB:0];
			RGC_GAIN_LOW: active_ofs = low_gain_level_offset_reg[LEVEL_MSB:0];
			default:      active_ofs = 6'h00;
		endcase
	end

	wire logic [6:0]  level_sum = {1'b0, level_sync_reg} + {1'b0, active_ofs};
	wire logic [10:0] product   = 11'(level_sum) * 11'(mult_eff);
	wire logic [10:0] scaled    = product >> div_shift;
	// samples inside the settle window, or while gain moves, are discarded
	wire logic        use_sample = take_sample & (settle_cnt_reg == 5'h00) & ~switching;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			energy_reg       <= 11'h000;
			energy_valid_reg <= 1'b0;
		end else if (clk_en) begin
			energy_valid_reg <= use_sample;
			if (use_sample) energy_reg <= scaled;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign reg_rdata              = rdata_reg;
	assign gain_sel               = gain_reg;
	assign freq_correction_enable = freq_corr_gain_control_reg[FREQ_CORR_EN_BIT];
	assign adc_clk_fast           = adc_clk_cfg_reg[ADC_CLK_SEL_BIT];
	assign sample_tick            = tick_reg;
	assign energy_value           = energy_reg;
	assign energy_valid           = energy_valid_reg;

endmodule

`default_nettype wire

/* File: verification/rgc_chk.sv */
// checker for the level and gain register bank, top-level ports only
// assumes one clock domain; mirrors of software writes stand beside it
`default_nettype none

module rgc_chk
	import rgc_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic              clk_sys,
	input wire logic              rst,
	input wire logic              clk_en,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0]        reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [7:0]        reg_rdata,
	input wire logic [5:0]        adc_level_pin,
	input wire logic              temp_busy_pin,
	input wire logic [1:0]        gain_sel,
	input wire logic              freq_correction_enable,
	input wire logic              adc_clk_fast,
	input wire logic              sample_tick,
	input wire logic [10:0]       energy_value,
	input wire logic              energy_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] cnt_reg;
	logic       seen_reg;
	logic       chg_reg;
	logic       fast_reg;
	logic       afc_reg;
	logic       sel_reg;
	logic [1:0] mode_reg;
	// ------------------------------------------------------------
	// decode and mirrors
	// ------------------------------------------------------------
	wire logic wr_ctl = reg_wr && clk_en && reg_addr == ADDR_W'(FREQ_GAIN_CTRL_OFS);
	wire logic wr_clk = reg_wr && clk_en && reg_addr == ADDR_W'(ADC_CLK_CFG_OFS);
	wire logic hit = reg_addr == ADDR_W'(ADC_CLK_CFG_OFS) ||
		(reg_addr >= ADDR_W'(MID_TO_LOW_THR_OFS) && reg_addr <= ADDR_W'(FREQ_GAIN_CTRL_OFS));
	// mirrors of what software asked for
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mode_reg <= FREQ_GAIN_CTRL_RST[1:0];
			afc_reg <= 1'b1;
			sel_reg <= 1'b1;
		end else begin
			if (wr_ctl) mode_reg <= reg_wdata[1:0];
			if (wr_ctl) afc_reg <= reg_wdata[7];
			if (wr_clk) sel_reg <= reg_wdata[4];
		end
	end
	// cycles since last tick; a rate change voids one period
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_reg <= 10'h000;
			seen_reg <= 1'b0;
			chg_reg <= 1'b0;
			fast_reg <= 1'b1;
		end else if (clk_en) begin
			cnt_reg <= sample_tick ? 10'h001 : cnt_reg + 10'h001;
			seen_reg <= seen_reg | sample_tick;
			chg_reg <= !sample_tick && (chg_reg || adc_clk_fast != fast_reg);
			fast_reg <= adc_clk_fast;
		end
	end
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	tick_period_a: assert property (
		sample_tick && seen_reg && !chg_reg |->
		cnt_reg == (adc_clk_fast ? 10'(ADC_FAST_CYC) : 10'(ADC_SLOW_CYC))
	) else $error("sample period length wrong");
	energy_after_tick_a: assert property (
		energy_valid |-> $past(sample_tick)
	) else $error("energy update without a sample");
	energy_hold_a: assert property (
		!energy_valid |-> $stable(energy_value)
	) else $error("energy value moved without valid");
	gain_cause_a: assert property (
		$changed(gain_sel) |-> $past(sample_tick) || $past(wr_ctl) || $past(wr_ctl, 2)
	) else $error("gain changed without sample or mode write");
	high_fix_a: assert property (
		(mode_reg[0] == mode_reg[1]) [*3] |-> gain_sel == RGC_GAIN_HIGH
	) else $error("gain not high in fixed mode");
	no_low_a: assert property (
		(mode_reg == MODE_HIGH_MID) [*3] |-> gain_sel != RGC_GAIN_LOW
	) else $error("low gain in high-mid mode");
	afc_bit_a: assert property (
		!$past(wr_ctl) |-> freq_correction_enable == afc_reg
	) else $error("frequency correction enable mismatch");
	clk_sel_a: assert property (
		!$past(wr_clk) |-> adc_clk_fast == sel_reg
	) else $error("converter clock select mismatch");
	unmapped_rd_a: assert property (
		reg_rd && clk_en && !hit |=> reg_rdata == 8'h00
	) else $error("unmapped read not zero");
	rdata_idle_a: assert property (
		clk_en && !reg_rd |=> reg_rdata == 8'h00
	) else $error("read data not zero when idle");
	energy_c: cover property (energy_valid);
	low_gain_c: cover property (gain_sel == RGC_GAIN_LOW);
	slow_tick_c: cover property (sample_tick && !adc_clk_fast);
endmodule

bind rgc_level_gain_regs rgc_chk #(.ADDR_W(ADDR_W)) chk_i (.clk_sys(clk_sys), .rst(rst),
	.clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_level_pin(adc_level_pin),
	.temp_busy_pin(temp_busy_pin), .gain_sel(gain_sel),
	.freq_correction_enable(freq_correction_enable), .adc_clk_fast(adc_clk_fast),
	.sample_tick(sample_tick), .energy_value(energy_value), .energy_valid(energy_valid));

`default_nettype wire

/* File: verification/rgc_adc_model.sv */
// model of the receive front end and shared level converter
// assumes the bench commands level and temperature-busy state
`default_nettype none

module rgc_adc_model (
	input  wire logic       clk_sys,
	input  wire logic [5:0] cmd_level,
	input  wire logic       cmd_busy,
	output logic      [5:0] adc_level_pin,
	output logic            temp_busy_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// pins launch just after an edge, like a result register would
	always_ff @(posedge clk_sys) begin
		adc_level_pin <= cmd_level;
		temp_busy_pin <= cmd_busy;
	end
endmodule

`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the level and gain register bank
// assumes the converter model on the pins and a 20 MHz clk_sys
`default_nettype none

module tb;
	import rgc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys, rst, reg_wr, reg_rd, fast, tick, fce, valid, busy_pin, busy, ce;
	logic [7:0]  addr, wdata, rdata;
	logic [5:0]  lvl_pin, lvl;
	logic [1:0]  gain;
	logic [10:0] energy;
	int          errors, num_checks, cyc;

	rgc_level_gain_regs uut (.clk_sys(clk_sys), .rst(rst), .clk_en(ce), .reg_addr(addr),
		.reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
		.adc_level_pin(lvl_pin), .temp_busy_pin(busy_pin), .gain_sel(gain),
		.freq_correction_enable(fce), .adc_clk_fast(fast), .sample_tick(tick),
		.energy_value(energy), .energy_valid(valid));
	rgc_adc_model adc (.clk_sys(clk_sys), .cmd_level(lvl), .cmd_busy(busy),
		.adc_level_pin(lvl_pin), .temp_busy_pin(busy_pin));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(string name, logic [10:0] exp, logic [10:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1; addr <= a; wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_rd <= 1'b1; addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = rdata;
	endtask
	// returns one cycle after the tick, when its results have landed
	task automatic next_sample(output int n);
		n = 0;
		do begin @(posedge clk_sys); #1 n++; end while (tick !== 1'b1 && n < 400);
		@(posedge clk_sys);
		#1;
	endtask
	function automatic logic [10:0] ed(logic [5:0] l, logic [5:0] o, logic [7:0] s);
		logic [10:0] v;
		logic [10:0] m;
		int          sh;
		m = (s[7:4] == 4'h0) ? 11'h001 : 11'(s[7:4]);
		sh = s[3] ? 3 : s[2] ? 2 : s[1] ? 1 : 0;
		v = 11'(l) + 11'(o);
		return (v * m) >> sh;
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		logic [7:0] a [12] = '{8'h08, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12,
			8'h13, 8'h14, 8'h15, 8'h16};
		logic [7:0] e [12] = '{8'h10, 8'h1E, 8'h02, 8'h1E, 8'h02, 8'h15, 8'h2B, 8'h01,
			8'hD4, 8'h00, 8'h82, 8'h00};
		logic [7:0] d;
		foreach (a[i]) begin rd(a[i], d); chk("reset", 11'(e[i]), 11'(d)); end
		@(posedge clk_sys);
		#1 chk("rdata idle", 11'h000, 11'(rdata));
		wr(MID_GAIN_OFS_OFS, 8'hFF);
		rd(MID_GAIN_OFS_OFS, d);
		chk("offset rw", 11'h0FF, 11'(d));
		wr(LEVEL_READING_OFS, 8'hFF);
		rd(LEVEL_READING_OFS, d);
		chk("reading ro", 11'h0C0, 11'(d));
		wr(LEVEL_READING_OFS, 8'h00);
		wr(MID_GAIN_OFS_OFS, 8'h15);
		$display("test reset done");
	endtask
	task automatic t_energy;
		logic [7:0] sc [4] = '{8'h00, 8'h42, 8'h0A, 8'hF1};
		logic [7:0] d;
		int         n;
		wr(FREQ_GAIN_CTRL_OFS, 8'h80);
		lvl <= 6'h21;
		repeat (3) next_sample(n);
		foreach (sc[i]) begin
			wr(ENERGY_SCALE_OFS, sc[i]);
			repeat (2) next_sample(n);
			chk("valid", 11'h001, 11'(valid));
			chk("energy", ed(6'h21, 6'h00, sc[i]), energy);
		end
		rd(LEVEL_READING_OFS, d);
		chk("reading", 11'h021, 11'(d));
		busy <= 1'b1;
		repeat (5) @(posedge clk_sys);
		lvl <= 6'h05;
		repeat (2) next_sample(n);
		chk("busy valid", 11'h000, 11'(valid));
		rd(LEVEL_READING_OFS, d);
		chk("busy hold", 11'h021, 11'(d));
		busy <= 1'b0;
		repeat (2) next_sample(n);
		chk("energy", ed(6'h05, 6'h00, 8'hF1), energy);
		$display("test energy done");
	endtask
	// thresholds stay at reset, each downward above its upward partner
	// settle wait stays at 0x01, never zero
	task automatic t_gain;
		int n;
		wr(ENERGY_SCALE_OFS, 8'h00);
		lvl <= 6'h30;
		wr(FREQ_GAIN_CTRL_OFS, 8'h82);
		next_sample(n);
		chk("to mid", 11'(RGC_GAIN_MID), 11'(gain));
		chk("switch valid", 11'h000, 11'(valid));
		repeat (2) begin
			next_sample(n);
			chk("conv hold", 11'(RGC_GAIN_MID), 11'(gain));
			chk("settle valid", 11'h000, 11'(valid));
		end
		next_sample(n);
		chk("to low", 11'(RGC_GAIN_LOW), 11'(gain));
		wr(FREQ_GAIN_CTRL_OFS, 8'h81);
		repeat (2) @(posedge clk_sys);
		#1 chk("mode mid", 11'(RGC_GAIN_MID), 11'(gain));
		for (int i = 0; i < 3; i++) begin
			next_sample(n);
			chk("settle", 11'(i == 2), 11'(valid));
		end
		chk("mid energy", ed(6'h30, 6'h15, 8'h00), energy);
		wr(FREQ_GAIN_CTRL_OFS, 8'h80);
		repeat (2) @(posedge clk_sys);
		#1 chk("mode high", 11'(RGC_GAIN_HIGH), 11'(gain));
		$display("test gain done");
	endtask
	task automatic t_ctrl;
		int         n;
		logic [7:0] d;
		ce <= 1'b0;
		wr(MID_GAIN_OFS_OFS, 8'h3F);
		ce <= 1'b1;
		rd(MID_GAIN_OFS_OFS, d);
		chk("frozen write", 11'h015, 11'(d));
		wr(ADC_CLK_CFG_OFS, 8'h00);
		repeat (2) @(posedge clk_sys);
		#1 chk("clk sel", 11'h000, 11'(fast));
		repeat (2) next_sample(n);
		chk("slow period", 11'(ADC_SLOW_CYC - 1), 11'(n));
		wr(ADC_CLK_CFG_OFS, 8'h10);
		repeat (2) next_sample(n);
		chk("fast period", 11'(ADC_FAST_CYC - 1), 11'(n));
		wr(FREQ_GAIN_CTRL_OFS, 8'h02);
		repeat (2) @(posedge clk_sys);
		#1 chk("afc off", 11'h000, 11'(fce));
		$display("test ctrl done");
	endtask

	// ------------------------------------------------------------
	// clock, watchdog, main sequence
	// ------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// whole run needs about 9000 cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			$display("FAIL timeout");
			tally_and_finish;
		end
	end
	initial begin
		rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; addr = 8'h00; wdata = 8'h00;
		lvl = 6'h00; busy = 1'b0; ce = 1'b1;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset;
		t_energy;
		t_gain;
		t_ctrl;
		tally_and_finish;
	end
endmodule

`default_nettype wire
